// ==== logic/aisrf_pkg.sv ====
package aisrf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ISEL_IO_OFFSET   = 6'h07;   // I/O instruction address
  localparam logic [7:0] DATA_SPACE_SHIFT = 8'h20;   // added for load/store access
  localparam logic [7:0] ISEL_DATA_OFFSET = 8'h27;
  localparam logic [7:0] ISEL_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // field layout of conversion_input_select
  // ----------------------------------------------------------------
  localparam int REF_HI_POS   = 7;
  localparam int REF_LO_POS   = 6;
  localparam int LALIGN_POS   = 5;
  localparam int CHAN_HI_POS  = 4;
  localparam int CHAN_LO_POS  = 0;

  // ----------------------------------------------------------------
  // result format
  // ----------------------------------------------------------------
  localparam int RES_W        = 10;
  localparam int PAIR_W       = 16;
  localparam int PAD_W        = PAIR_W - RES_W;
  localparam int SE_FULL      = 1024;             // single-ended scale
  localparam int DIFF_FULL    = 512;              // differential scale
  localparam logic [9:0] SE_MAX   = 10'h3FF;
  localparam logic [9:0] DIFF_MIN = 10'h200;
  localparam logic [9:0] DIFF_MAX = 10'h1FF;
  localparam logic [4:0] FIRST_DIFF_CHAN = 5'h08; // codes below are single-ended
  localparam logic [4:0] BANDGAP_CHAN    = 5'h1E; // fixed single-ended sources
  localparam logic [4:0] GROUND_CHAN     = 5'h1F;

  // ----------------------------------------------------------------
  // reference decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AISRF_REF_EXT_PIN  = 2'b00,
    AISRF_REF_SUPPLY   = 2'b01,
    AISRF_REF_RESERVED = 2'b10,
    AISRF_REF_INT_2V56 = 2'b11
  } aisrf_ref_e;

  // conversion phase, gray along idle -> busy -> done
  typedef enum logic [1:0] {
    AISRF_IDLE = 2'b00,
    AISRF_BUSY = 2'b01,
    AISRF_DONE = 2'b11
  } aisrf_phase_e;

endpackage : aisrf_pkg

// ==== logic/aisrf_result_format.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// result pair alignment and sign
// ------------------------------------------------------------------
module aisrf_result_format
  import aisrf_pkg::*;
(
  input  wire logic               leftAlign,
  input  wire logic [RES_W-1:0]   rawCode,
  output logic      [PAIR_W-1:0]  pairOut,
  output logic                    signNeg
);

  // purely combinational so an alignment change shows at once
  always_comb begin
    if (leftAlign) begin
      pairOut = {rawCode, {PAD_W{1'b0}}};
    end else begin
      pairOut = {{PAD_W{1'b0}}, rawCode};
    end
  end

  assign signNeg = rawCode[RES_W-1];

endmodule : aisrf_result_format

// ==== logic/aisrf_input_select.sv ====
// Function
// - single-ended result is unsigned code, 0x000 ground to 0x3FF reference minus step
// - differential result is two's complement, 0x200 most negative to 0x1FF
// - top result bit is sign for differential: one negative, zero positive
// - while done flag is high the finished result stays in the pair
// - left-align bit one presents left adjusted, zero right adjusted
// - alignment change alters result pair presentation at once
// - reference change during conversion applies only after it completes
// - reference codes: 00 external pin, 01 supply, 10 reserved, 11 internal 2.56V
// - input select register at I/O 0x07, data 0x27, reset 0x00, fields read/write
// - done flag set when conversion finishes and result pair updated
// - channel field change during conversion applies only after completion
`timescale 1ns/1ps
module aisrf_input_select
  import aisrf_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  // processor I/O port
  input  wire logic [7:0]        ioAddr,
  input  wire logic              ioDataSpace,
  input  wire logic              ioWrite,
  input  wire logic              ioRead,
  input  wire logic [7:0]        ioWdata,
  output logic      [7:0]        ioRdata,
  output logic                   ioHit,
  // conversion sequencer side
  input  wire logic              convStart,
  input  wire logic              convEnd,
  input  wire logic [RES_W-1:0]  convCode,
  input  wire logic              doneClear,
  // analog front end steering
  output logic      [1:0]        activeRef,
  output logic      [4:0]        activeChannel,
  output logic                   activeDiff,
  output logic                   refExtPin,
  output logic                   refSupply,
  output logic                   refInternal,
  output logic                   refReserved,
  // formatted result
  output logic      [7:0]        resultLowByte,
  output logic      [7:0]        resultHighByte,
  output logic                   resultSignBit,
  output logic                   conversionDoneFlag,
  output logic                   convBusy
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic selHit;
  // data-space accesses carry the 0x20 bias; I/O accesses stop at 0x3F
  always_comb begin
    if (ioDataSpace) begin
      selHit = (ioAddr == ISEL_DATA_OFFSET);
    end else begin
      selHit = (ioAddr[7:6] == 2'b00) && (ioAddr[5:0] == ISEL_IO_OFFSET);
    end
  end
  assign ioHit = selHit & (ioRead | ioWrite);

  // ----------------------------------------------------------------
  // conversion_input_select register
  // ----------------------------------------------------------------
  logic [7:0] inputSelect_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      inputSelect_ff <= ISEL_RESET;
    end else if (ioWrite && selHit) begin
      inputSelect_ff <= ioWdata;
    end
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      ioRdata <= 8'h00;
    end else if (ioRead && selHit) begin
      ioRdata <= inputSelect_ff;
    end else begin
      ioRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // conversion phase
  // ----------------------------------------------------------------
  aisrf_phase_e phase_ff;
  aisrf_phase_e nxt_phase;
  always_comb begin
    case (phase_ff)
      AISRF_IDLE: nxt_phase = convStart ? AISRF_BUSY : AISRF_IDLE;
      AISRF_BUSY: nxt_phase = convEnd ? AISRF_DONE : AISRF_BUSY;
      AISRF_DONE: nxt_phase = convStart ? AISRF_BUSY : AISRF_IDLE;
      default:    nxt_phase = AISRF_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_ff <= AISRF_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end
  assign convBusy = (phase_ff == AISRF_BUSY);

  // ----------------------------------------------------------------
  // active selection: shadow copy latched only outside a conversion or at its completing edge
  // ----------------------------------------------------------------
  // the analog path must not switch mid-sample, so the field only
  // reaches the front end while idle or at the completing edge
  logic [1:0] activeRef_ff;
  logic [4:0] activeChannel_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      activeRef_ff     <= 2'b00;
      activeChannel_ff <= 5'h00;
    end else if (!convBusy || convEnd) begin
      activeRef_ff     <= inputSelect_ff[REF_HI_POS:REF_LO_POS];
      activeChannel_ff <= inputSelect_ff[CHAN_HI_POS:CHAN_LO_POS];
    end
  end
  assign activeRef     = activeRef_ff;
  assign activeChannel = activeChannel_ff;
  // codes 0x08..0x1D are pairs; 0x1E and 0x1F are fixed single-ended sources
  assign activeDiff    = (activeChannel_ff >= FIRST_DIFF_CHAN) && (activeChannel_ff < BANDGAP_CHAN);

  // reference decode, one-hot toward the analog switches
  always_comb begin
    refExtPin   = 1'b0;
    refSupply   = 1'b0;
    refInternal = 1'b0;
    refReserved = 1'b0;
    case (aisrf_ref_e'(activeRef_ff))
      AISRF_REF_EXT_PIN:  refExtPin   = 1'b1;
      AISRF_REF_SUPPLY:   refSupply   = 1'b1;
      AISRF_REF_RESERVED: refReserved = 1'b1;
      AISRF_REF_INT_2V56: refInternal = 1'b1;
      default:            refReserved = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // result capture and done flag
  // ----------------------------------------------------------------
  // the code is latched as delivered: unsigned for single-ended,
  // two's complement for pairs; no rescaling is done here
  logic [RES_W-1:0] result_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_ff <= '0;
    end else if (convBusy && convEnd) begin
      result_ff <= convCode;
    end
  end

  // set wins over clear
  logic done_ff;
  always_ff @(posedge mclk) begin
    if (srst) begin
      done_ff <= 1'b0;
    end else if (convBusy && convEnd) begin
      done_ff <= 1'b1;
    end else if (doneClear) begin
      done_ff <= 1'b0;
    end
  end
  assign conversionDoneFlag = done_ff;

  // ----------------------------------------------------------------
  // presentation
  // ----------------------------------------------------------------
  logic [PAIR_W-1:0] pair;
  logic              signNeg;
  aisrf_result_format u_format (
    .leftAlign (inputSelect_ff[LALIGN_POS]),
    .rawCode   (result_ff),
    .pairOut   (pair),
    .signNeg   (signNeg)
  );
  assign resultLowByte  = pair[7:0];
  assign resultHighByte = pair[15:8];
  assign resultSignBit  = signNeg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reg_reset_a : assert property (@(posedge mclk) srst |=> inputSelect_ff == ISEL_RESET)
    else $error("select register not zero after reset");

  reg_write_a : assert property (@(posedge mclk) disable iff (srst)
    (ioWrite && selHit) |=> inputSelect_ff == $past(ioWdata))
    else $error("select register write lost");

  ref_hold_a : assert property (@(posedge mclk) disable iff (srst)
    (convBusy && !convEnd) |=> activeRef_ff == $past(activeRef_ff))
    else $error("reference changed during conversion");

  chan_hold_a : assert property (@(posedge mclk) disable iff (srst)
    (convBusy && !convEnd) |=> activeChannel_ff == $past(activeChannel_ff))
    else $error("channel changed during conversion");

  ref_apply_a : assert property (@(posedge mclk) disable iff (srst)
    (convBusy && convEnd && !(ioWrite && selHit)) |=>
      activeRef_ff == inputSelect_ff[REF_HI_POS:REF_LO_POS])
    else $error("reference not applied at completion");

  done_set_a : assert property (@(posedge mclk) disable iff (srst)
    (convBusy && convEnd) |=> done_ff && result_ff == $past(convCode))
    else $error("done flag or result not updated");

  result_hold_a : assert property (@(posedge mclk) disable iff (srst)
    (done_ff && !convBusy) |=> $stable(result_ff))
    else $error("result changed while done");

  left_align_a : assert property (@(posedge mclk) disable iff (srst)
    inputSelect_ff[LALIGN_POS] |-> resultHighByte == result_ff[9:2]
      && resultLowByte == {result_ff[1:0], 6'h00})
    else $error("left aligned pair wrong");

  right_align_a : assert property (@(posedge mclk) disable iff (srst)
    !inputSelect_ff[LALIGN_POS] |-> resultHighByte == {6'h00, result_ff[9:8]}
      && resultLowByte == result_ff[7:0])
    else $error("right aligned pair wrong");

  // the sign flag must agree with the top result bit as software sees it in the pair
  sign_bit_a : assert property (@(posedge mclk) disable iff (srst)
    resultSignBit == (inputSelect_ff[LALIGN_POS] ? resultHighByte[7] : resultHighByte[1]))
    else $error("sign bit does not match the result pair");

  ref_onehot_a : assert property (@(posedge mclk) disable iff (srst)
    $onehot({refExtPin, refSupply, refInternal, refReserved}) &&
      (refInternal == (activeRef_ff == 2'b11)))
    else $error("reference decode wrong");

endmodule : aisrf_input_select

// ==== testbench/aisrf_conv_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sequencer and analog source stand-in
// ----------------------------------------------------------------
module aisrf_conv_model
  import aisrf_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             go,
  input  wire logic [RES_W-1:0] code,
  input  wire logic [7:0]       lag,
  output logic                  convStart,
  output logic                  convEnd,
  output logic      [RES_W-1:0] convCode
);
  logic [7:0] cnt_ff;
  logic       busy_ff;
  // code toggles outside convEnd so the block cannot lean on a stale value
  always_ff @(posedge mclk) begin
    convStart <= 1'b0;
    convEnd   <= 1'b0;
    convCode  <= ~convCode;
    if (srst) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 8'h00;
      convCode <= 10'h000;
    end else if (go && !busy_ff) begin
      convStart <= 1'b1;
      busy_ff   <= 1'b1;
      cnt_ff    <= lag;
    end else if (busy_ff && cnt_ff == 8'h00) begin
      convEnd  <= 1'b1;
      convCode <= code;
      busy_ff  <= 1'b0;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule : aisrf_conv_model

// ==== testbench/adc_input_select_result_format_tb_top.sv ====
`timescale 1ns/1ps
module adc_input_select_result_format_tb_top
  import aisrf_pkg::*;
;
  logic             mclk = 1'b0, srst = 1'b1, ioDataSpace = 1'b0, ioWrite = 1'b0, ioRead = 1'b0;
  logic             doneClear = 1'b0, go = 1'b0, ioHit, convStart, convEnd, resultSignBit;
  logic             conversionDoneFlag, convBusy, activeDiff, refExtPin, refSupply, refInternal, refReserved;
  logic [7:0]       ioAddr = 8'h00, ioWdata = 8'h00, lag = 8'h00, ioRdata, resultLowByte, resultHighByte;
  logic [RES_W-1:0] code = 10'h000, convCode;
  logic [1:0]       activeRef;
  logic [4:0]       activeChannel;
  int               fails = 0, n_checks = 0;

  always #4 mclk = ~mclk;

  aisrf_input_select u_dut (.mclk, .srst, .ioAddr, .ioDataSpace, .ioWrite, .ioRead, .ioWdata, .ioRdata,
    .ioHit, .convStart, .convEnd, .convCode, .doneClear, .activeRef, .activeChannel, .activeDiff,
    .refExtPin, .refSupply, .refInternal, .refReserved, .resultLowByte, .resultHighByte, .resultSignBit,
    .conversionDoneFlag, .convBusy);
  aisrf_conv_model u_model (.mclk, .srst, .go, .code, .lag, .convStart, .convEnd, .convCode);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // one-cycle strobe; a cycle gap keeps back-to-back calls legal
  task automatic wr(input logic [7:0] a, input logic ds, input logic [7:0] d);
    @(posedge mclk);
    ioAddr      <= a;
    ioDataSpace <= ds;
    ioWdata     <= d;
    ioWrite     <= 1'b1;
    @(posedge mclk);
    ioWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic ds, input logic [7:0] exp);
    @(posedge mclk);
    ioAddr      <= a;
    ioDataSpace <= ds;
    ioRead      <= 1'b1;
    #1 chk(ioHit, ds ? (a == ISEL_DATA_OFFSET) : (a == {2'b00, ISEL_IO_OFFSET}));
    @(posedge mclk);
    ioRead <= 1'b0;
    #1 chk(ioRdata, exp);
  endtask : rd

  // bounded wait on busy (sel 0) or done (sel 1)
  task automatic waitFor(input logic sel);
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge mclk);
      #1;
      if ((sel ? conversionDoneFlag : convBusy) === 1'b1)
        break;
    end
    if (i == 64) begin
      fails++;
      results();
    end
  endtask : waitFor

  task automatic start(input logic [9:0] c, input logic [7:0] l);
    @(posedge mclk);
    code      <= c;
    lag       <= l;
    go        <= 1'b1;
    doneClear <= 1'b1;   // a stale flag would end the next wait at once
    @(posedge mclk);
    go        <= 1'b0;
    doneClear <= 1'b0;
    waitFor(1'b0);
  endtask : start

  function automatic logic [15:0] pair();
    return {resultHighByte, resultLowByte};
  endfunction : pair

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(8'h07, 1'b0, 8'h00);
    chk(refExtPin, 1'b1);
    chk(conversionDoneFlag, 1'b0);
    wr(8'h07, 1'b0, 8'hED);
    rd(8'h07, 1'b0, 8'hED);
    rd(8'h27, 1'b1, 8'hED);
    wr(8'h27, 1'b1, 8'h5A);
    rd(8'h07, 1'b0, 8'h5A);
    wr(8'h26, 1'b1, 8'hFF);
    rd(8'h06, 1'b0, 8'h00);
    rd(8'h07, 1'b1, 8'h00);
    rd(8'h27, 1'b1, 8'h5A);
  endtask : t_regs

  task automatic t_refs();
    for (int r = 0; r < 4; r++) begin
      wr(8'h07, 1'b0, {r[1:0], 1'b0, 4'hF, r[0]});
      repeat (2) @(posedge mclk);
      #1 chk(activeRef, r[1:0]);
      chk({refInternal, refReserved, refSupply, refExtPin}, 4'h1 << r);
      chk({activeChannel, activeDiff}, {4'hF, r[0], 1'b0});
    end
  endtask : t_refs

  // selection frozen in flight, alignment is not
  task automatic t_hold();
    wr(8'h07, 1'b0, 8'h49);
    start(10'h270, 8'h0A);
    wr(8'h07, 1'b0, 8'hC3);
    #1 chk({activeRef, activeChannel, activeDiff}, {2'b01, 5'h09, 1'b1});
    chk(convBusy, 1'b1);
    waitFor(1'b1);
    chk({activeRef, activeChannel, activeDiff}, {2'b11, 5'h03, 1'b0});
    chk(convBusy, 1'b0);
    chk(pair(), 16'h0270);
    chk(resultSignBit, 1'b1);
    start(10'h1FF, 8'h0C);
    wr(8'h07, 1'b0, 8'hED);
    #1 chk(pair(), 16'h9C00);
    chk(conversionDoneFlag, 1'b0);
    waitFor(1'b1);
    chk({activeRef, activeChannel, activeDiff}, {2'b11, 5'h0D, 1'b1});
    chk(pair(), 16'h7FC0);
    chk(resultSignBit, 1'b0);
    wr(8'h07, 1'b0, 8'hCD);
    #1 chk(pair(), 16'h01FF);
  endtask : t_hold

  // single-ended full scale, then the flag is cleared and the result stays
  task automatic t_clear();
    wr(8'h07, 1'b0, 8'h47);
    start(10'h3FF, 8'h00);
    waitFor(1'b1);
    repeat (3) @(posedge mclk);
    #1 chk(pair(), 16'h03FF);
    chk(conversionDoneFlag, 1'b1);
    @(posedge mclk);
    doneClear <= 1'b1;
    @(posedge mclk);
    doneClear <= 1'b0;
    #1 chk(conversionDoneFlag, 1'b0);
    chk(pair(), 16'h03FF);
  endtask : t_clear

  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_refs();
    t_hold();
    t_clear();
    results();
  end
endmodule : adc_input_select_result_format_tb_top
